/* hw/boot_seq_pkg.sv */
package boot_seq_pkg;
    // Core clock rate in MHz and the crystal reference it is derived from.
    localparam int CORE_CLOCK_MHZ = 60;
    localparam int CRYSTAL_MHZ = 24;
    // Boot ROM start address and size in bytes.
    localparam logic [15:0] BOOT_ROM_START = 16'h0000;
    localparam int BOOT_ROM_BYTES = 8192;
    // Code RAM size in bytes.
    localparam int CODE_RAM_BYTES = 32768;
    localparam int CODE_ADDR_W = 15;
    // Reset debounce length in core clocks.
    localparam int DEBOUNCE_CYCLES = 16;
    // Header layout in the EEPROM: signature word, firmware type, vendor and product IDs.
    localparam logic [15:0] HDR_SIG_ADDR = 16'h0000;
    localparam logic [15:0] HDR_TYPE_ADDR = 16'h0002;
    localparam logic [15:0] HDR_VID_ADDR = 16'h0003;
    localparam logic [15:0] HDR_PID_ADDR = 16'h0005;
    localparam logic [15:0] HDR_IMAGE_ADDR = 16'h0010;
    // Firmware type bit: set means enumerate before download.
    localparam int TYPE_ENUM_FIRST_BIT = 0;
    // Reset values of the USB function state.
    localparam logic [6:0] USB_ADDR_RESET = 7'h00;
endpackage

/* hw/reset_boot_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Async low reset, debounced on core clock.
// - Reset clears state; address zero, disconnected.
// - Processor fetch starts at ROM address zero.
// - Read EEPROM signature, compare with expected.
// - Signature match: copy image into code RAM.
// - No valid code: boot from USB download.
// - Fetch vendor and product IDs first.
// - Firmware type selects enumerate-first or stay-disconnected.
// - Assert low power grant during enumeration.
// - No bus power when self-powered: no grant.
// - High power grant only under firmware control.
// - Pin defaults to input with pulldown.
// - General and card-detect inputs raise wake-up.
// - Core runs at 60 MHz from 24 MHz.
module reset_boot_sequencer #(
    parameter logic [15:0] BOOT_SIGNATURE = 16'hA55A, // Expected signature; value arbitrary.
    parameter int IMAGE_BYTES = boot_seq_pkg::CODE_RAM_BYTES,
    parameter int DEBOUNCE = boot_seq_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic master_reset_n,
    // Byte read port toward the serial EEPROM engine.
    output logic ee_read_req,
    output logic [15:0] ee_read_addr,
    input wire logic ee_read_done,
    input wire logic ee_read_error,
    input wire logic [7:0] ee_read_data,
    // Code RAM write port.
    output logic ram_write,
    output logic [boot_seq_pkg::CODE_ADDR_W-1:0] ram_addr,
    output logic [7:0] ram_data,
    // USB function control.
    output logic [6:0] usb_address,
    output logic usb_connect,
    output logic [15:0] vendor_id,
    output logic [15:0] product_id,
    input wire logic enumeration_done,
    input wire logic usb_download_done,
    input wire logic vbus_present,
    input wire logic self_powered,
    output logic usb_download_mode,
    // Processor hand-off.
    output logic cpu_run,
    output logic [15:0] cpu_fetch_addr,
    output logic boot_done,
    // Firmware controls once it runs.
    input wire logic fw_connect,
    input wire logic fw_high_power,
    input wire logic fw_low_power,
    input wire logic fw_pull_up,
    input wire logic fw_pull_down,
    // Power grant open-drain pins: out value and enable.
    output logic low_power_grant_o,
    output logic low_power_grant_oe,
    output logic high_power_grant_o,
    output logic high_power_grant_oe,
    // Pull control of the pulldown-default pin.
    output logic port_pin_pulldown_default_pu,
    output logic port_pin_pulldown_default_pd,
    // Wake sources.
    input wire logic wake_enable,
    input wire logic wake_input_a,
    input wire logic wake_input_b,
    input wire logic card_detect_a,
    input wire logic card_detect_b,
    output logic remote_wake
);

    // Boot sequence states.
    typedef enum logic [3:0] {
        ST_DEBOUNCE,
        ST_SIG_LO,
        ST_SIG_HI,
        ST_TYPE,
        ST_ID,
        ST_ENUM,
        ST_COPY,
        ST_USB_LOAD,
        ST_RUN
    } boot_state_e;

    boot_state_e state_reg; // Current boot step.
    logic [$clog2(DEBOUNCE+1)-1:0] deb_cnt_reg; // Reset debounce counter.
    logic [15:0] sig_reg; // Signature being assembled.
    logic type_enum_first_reg; // Enumerate before download.
    logic [1:0] id_idx_reg; // Which ID byte is fetched.
    logic [15:0] copy_cnt_reg; // Image bytes copied.
    logic req_pending_reg; // A read has been issued and awaits completion.
    logic connected_by_boot_reg; // Boot code has connected.
    logic low_grant_reg; // Boot code asserts the low power grant.
    logic [3:0] wake_prev_reg; // Previous wake input levels.
    logic [3:0] wake_now; // Current wake input levels.

    // Debounce the master reset: the sequence only starts after it has stayed high
    // for a full window, so glitches on the pin cannot launch a half-done boot.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            deb_cnt_reg <= '0;
        end else if (!master_reset_n) begin
            deb_cnt_reg <= '0;
        end else if (deb_cnt_reg != DEBOUNCE[$clog2(DEBOUNCE+1)-1:0]) begin
            deb_cnt_reg <= deb_cnt_reg + 1'b1;
        end
    end

    // Main boot sequence; a low master reset at any time returns it to the start.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_DEBOUNCE;
            sig_reg <= 16'h0000;
            type_enum_first_reg <= 1'b0;
            id_idx_reg <= 2'h0;
            copy_cnt_reg <= 16'h0000;
        end else if (!master_reset_n) begin
            state_reg <= ST_DEBOUNCE;
            sig_reg <= 16'h0000;
            type_enum_first_reg <= 1'b0;
            id_idx_reg <= 2'h0;
            copy_cnt_reg <= 16'h0000;
        end else begin
            case (state_reg)
                ST_DEBOUNCE: begin
                    if (deb_cnt_reg == DEBOUNCE[$clog2(DEBOUNCE+1)-1:0]) begin
                        state_reg <= ST_SIG_LO;
                    end
                end
                ST_SIG_LO: begin
                    if (ee_read_done && ee_read_error) begin
                        state_reg <= ST_USB_LOAD;
                    end else if (ee_read_done) begin
                        sig_reg[7:0] <= ee_read_data;
                        state_reg <= ST_SIG_HI;
                    end
                end
                ST_SIG_HI: begin
                    if (ee_read_done && ee_read_error) begin
                        state_reg <= ST_USB_LOAD;
                    end else if (ee_read_done) begin
                        sig_reg[15:8] <= ee_read_data;
                        state_reg <= ST_TYPE;
                    end
                end
                ST_TYPE: begin
                    // Type byte and IDs are still read when the signature is wrong, since the
                    // IDs are needed for enumeration on the USB download path too.
                    if (ee_read_done) begin
                        type_enum_first_reg <= ee_read_error ? 1'b1
                            : ee_read_data[boot_seq_pkg::TYPE_ENUM_FIRST_BIT];
                        id_idx_reg <= 2'h0;
                        state_reg <= ST_ID;
                    end
                end
                ST_ID: begin
                    if (ee_read_done) begin
                        id_idx_reg <= id_idx_reg + 2'h1;
                        if (id_idx_reg == 2'h3) begin
                            state_reg <= type_enum_first_reg ? ST_ENUM
                                : (sig_reg == BOOT_SIGNATURE ? ST_COPY : ST_USB_LOAD);
                        end
                    end
                end
                ST_ENUM: begin
                    if (enumeration_done) begin
                        state_reg <= (sig_reg == BOOT_SIGNATURE) ? ST_COPY : ST_USB_LOAD;
                    end
                end
                ST_COPY: begin
                    if (ee_read_done && ee_read_error) begin
                        state_reg <= ST_USB_LOAD;
                    end else if (ee_read_done) begin
                        copy_cnt_reg <= copy_cnt_reg + 16'h0001;
                        if (copy_cnt_reg == 16'(IMAGE_BYTES - 1)) begin
                            state_reg <= ST_RUN;
                        end
                    end
                end
                ST_USB_LOAD: begin
                    if (usb_download_done) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_reg <= ST_RUN;
                end
                default: begin
                    state_reg <= ST_DEBOUNCE;
                end
            endcase
        end
    end

    // Vendor and product IDs gathered from the header, low byte first.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vendor_id <= 16'h0000;
            product_id <= 16'h0000;
        end else if (state_reg == ST_ID && ee_read_done && !ee_read_error) begin
            case (id_idx_reg)
                2'h0: vendor_id[7:0] <= ee_read_data;
                2'h1: vendor_id[15:8] <= ee_read_data;
                2'h2: product_id[7:0] <= ee_read_data;
                default: product_id[15:8] <= ee_read_data;
            endcase
        end
    end

    // One outstanding read at a time; the request is a single-cycle pulse.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            req_pending_reg <= 1'b0;
        end else if (!master_reset_n || ee_read_done) begin
            req_pending_reg <= 1'b0;
        end else if (ee_read_req) begin
            req_pending_reg <= 1'b1;
        end
    end

    // A read is wanted in every state that consumes EEPROM bytes.
    always_comb begin
        ee_read_req = 1'b0;
        ee_read_addr = 16'h0000;
        if (master_reset_n && !req_pending_reg && !ee_read_done) begin
            case (state_reg)
                ST_SIG_LO: begin
                    ee_read_req = 1'b1;
                    ee_read_addr = boot_seq_pkg::HDR_SIG_ADDR;
                end
                ST_SIG_HI: begin
                    ee_read_req = 1'b1;
                    ee_read_addr = boot_seq_pkg::HDR_SIG_ADDR + 16'h0001;
                end
                ST_TYPE: begin
                    ee_read_req = 1'b1;
                    ee_read_addr = boot_seq_pkg::HDR_TYPE_ADDR;
                end
                ST_ID: begin
                    ee_read_req = 1'b1;
                    ee_read_addr = boot_seq_pkg::HDR_VID_ADDR + {14'h0000, id_idx_reg};
                end
                ST_COPY: begin
                    ee_read_req = 1'b1;
                    ee_read_addr = boot_seq_pkg::HDR_IMAGE_ADDR + copy_cnt_reg;
                end
                default: begin
                    ee_read_req = 1'b0;
                end
            endcase
        end
    end

    // Code RAM write, registered from each good image byte.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ram_write <= 1'b0;
            ram_addr <= '0;
            ram_data <= 8'h00;
        end else begin
            ram_write <= state_reg == ST_COPY && ee_read_done && !ee_read_error;
            ram_addr <= copy_cnt_reg[boot_seq_pkg::CODE_ADDR_W-1:0];
            ram_data <= ee_read_data;
        end
    end

    // USB connect: boot connects for enumerate-first images; otherwise firmware does.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            connected_by_boot_reg <= 1'b0;
        end else if (!master_reset_n) begin
            connected_by_boot_reg <= 1'b0;
        end else if (state_reg == ST_ENUM) begin
            connected_by_boot_reg <= 1'b1;
        end
    end

    // Low power grant: raised while enumerating, unless self-powered with no bus power.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_grant_reg <= 1'b0;
        end else if (!master_reset_n) begin
            low_grant_reg <= 1'b0;
        end else if (state_reg == ST_ENUM || state_reg == ST_USB_LOAD) begin
            low_grant_reg <= vbus_present || !self_powered;
        end
    end

    // Outputs driven from state; firmware takes over once running.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            usb_address <= boot_seq_pkg::USB_ADDR_RESET;
            usb_connect <= 1'b0;
            usb_download_mode <= 1'b0;
            cpu_run <= 1'b0;
            cpu_fetch_addr <= boot_seq_pkg::BOOT_ROM_START;
            boot_done <= 1'b0;
            low_power_grant_oe <= 1'b0;
            high_power_grant_oe <= 1'b0;
            port_pin_pulldown_default_pu <= 1'b0;
            port_pin_pulldown_default_pd <= 1'b1;
        end else begin
            usb_address <= boot_seq_pkg::USB_ADDR_RESET;
            usb_connect <= master_reset_n && (connected_by_boot_reg || (state_reg == ST_RUN && fw_connect));
            usb_download_mode <= state_reg == ST_USB_LOAD;
            // The processor leaves reset fetching at the start of the boot ROM.
            cpu_run <= master_reset_n && state_reg != ST_DEBOUNCE;
            cpu_fetch_addr <= boot_seq_pkg::BOOT_ROM_START;
            boot_done <= state_reg == ST_RUN;
            low_power_grant_oe <= (state_reg == ST_RUN) ? fw_low_power : low_grant_reg;
            high_power_grant_oe <= state_reg == ST_RUN && fw_high_power;
            port_pin_pulldown_default_pu <= state_reg == ST_RUN && fw_pull_up;
            port_pin_pulldown_default_pd <= (state_reg == ST_RUN) ? fw_pull_down : 1'b1;
        end
    end

    // Open-drain pins pull low when asserted, so the driven value is always zero.
    assign low_power_grant_o = 1'b0;
    assign high_power_grant_o = 1'b0;

    // Wake events: any edge on an enabled source gives a one-cycle pulse.
    assign wake_now = {card_detect_b, card_detect_a, wake_input_b, wake_input_a};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wake_prev_reg <= 4'hF; // Pins idle high on their pullups, so reset brings no false edge.
            remote_wake <= 1'b0;
        end else begin
            wake_prev_reg <= wake_now;
            remote_wake <= wake_enable && (wake_now != wake_prev_reg);
        end
    end

    // The 60 MHz core clock arrives from the transceiver PLL; nothing here divides it.
endmodule // reset_boot_sequencer

`default_nettype wire

/* tb/ee_model.sv */
`timescale 1ns/1ns
`default_nettype none
// EEPROM behind the byte read port, answering each request after a short or long wait.
module ee_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ee_read_req,
    input wire logic [15:0] ee_read_addr,
    input wire logic good_sig,
    input wire logic enum_first,
    input wire logic slow,
    input wire logic [15:0] err_at,
    output logic ee_read_done,
    output logic ee_read_error,
    output logic [7:0] ee_read_data
);
    logic busy_reg; // A request waits for its answer.
    logic [1:0] wait_reg; // Cycles left before answering.
    logic [15:0] addr_reg; // Address taken with the request.
    // Header words low byte first; image bytes are a pattern of the address.
    function automatic logic [7:0] mem(input logic [15:0] a);
        case (a)
            16'h0000: return good_sig ? 8'h5A : 8'h00;
            16'h0001: return 8'hA5;
            16'h0002: return {7'h00, enum_first};
            16'h0003: return 8'h34;
            16'h0004: return 8'h12;
            16'h0005: return 8'h78;
            16'h0006: return 8'h56;
            default: return a[7:0] ^ 8'h3C;
        endcase
    endfunction
    // Data lines toggle whenever no answer stands, so a stale byte is never reused.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            wait_reg <= 2'h0;
            addr_reg <= 16'h0000;
            ee_read_done <= 1'b0;
            ee_read_error <= 1'b0;
            ee_read_data <= 8'h00;
        end else begin
            ee_read_done <= 1'b0;
            ee_read_error <= 1'b0;
            ee_read_data <= ~ee_read_data;
            if (ee_read_req && !busy_reg) begin
                busy_reg <= 1'b1;
                addr_reg <= ee_read_addr;
                wait_reg <= slow ? 2'h3 : 2'h0;
            end else if (busy_reg && wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end else if (busy_reg) begin
                busy_reg <= 1'b0;
                ee_read_done <= 1'b1;
                ee_read_error <= addr_reg == err_at;
                ee_read_data <= mem(addr_reg);
            end
        end
    end
endmodule // ee_model
`default_nettype wire

/* tb/reset_boot_sequencer_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// Watches the sequencer ports for reset defaults and the order of the boot reads.
module reset_boot_sequencer_checker #(
    parameter int DEBOUNCE = 16
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic master_reset_n,
    input wire logic ee_read_req,
    input wire logic [15:0] ee_read_addr,
    input wire logic ee_read_done,
    input wire logic [7:0] ee_read_data,
    input wire logic ram_write,
    input wire logic [7:0] ram_data,
    input wire logic [6:0] usb_address,
    input wire logic [15:0] cpu_fetch_addr,
    input wire logic boot_done,
    input wire logic high_power_grant_oe,
    input wire logic port_pin_pulldown_default_pd
);
    // A read may only follow a full debounce window of released master reset.
    localparam int DEB_MIN = DEBOUNCE;
    logic [7:0] hi_cnt_reg; // Cycles since the master reset went high.
    logic seen_reg; // A read was asked for since the last master reset.
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Saturating count of cycles with the master reset released.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) hi_cnt_reg <= 8'h00;
        else if (!master_reset_n) hi_cnt_reg <= 8'h00;
        else if (hi_cnt_reg != 8'hFF) hi_cnt_reg <= hi_cnt_reg + 8'h01;
    end
    // Marks that the first read of a boot has gone out.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) seen_reg <= 1'b0;
        else if (!master_reset_n) seen_reg <= 1'b0;
        else if (ee_read_req) seen_reg <= 1'b1;
    end
    property p_usb_addr; usb_address == 7'h00; endproperty
    a_usb_addr: assert property (p_usb_addr) else $error("usb address not zero");
    property p_fetch; cpu_fetch_addr == 16'h0000; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address not zero");
    property p_high; !boot_done |-> !high_power_grant_oe; endproperty
    a_high: assert property (p_high) else $error("high grant before firmware");
    property p_debounce; ee_read_req |-> hi_cnt_reg >= DEB_MIN; endproperty
    a_debounce: assert property (p_debounce) else $error("read before debounce ended");
    property p_pulse; ee_read_req |=> !ee_read_req; endproperty
    a_pulse: assert property (p_pulse) else $error("read request longer than one cycle");
    property p_first; ee_read_req && !seen_reg |-> ee_read_addr == 16'h0000; endproperty
    a_first: assert property (p_first) else $error("first read not the signature");
    property p_ram; ram_write |-> $past(ee_read_done) && ram_data == $past(ee_read_data); endproperty
    a_ram: assert property (p_ram) else $error("code write not the byte read");
    property p_pull; $rose(rst_n) |-> port_pin_pulldown_default_pd; endproperty
    a_pull: assert property (p_pull) else $error("pulldown off after reset");
endmodule // reset_boot_sequencer_checker
bind reset_boot_sequencer reset_boot_sequencer_checker #(.DEBOUNCE(DEBOUNCE)) i_chk (.*);
`default_nettype wire

/* tb/reset_boot_sequencer_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Bench acting as USB side and firmware, with the EEPROM model on the read port.
module reset_boot_sequencer_tb_top;
    localparam int IMG = 8; // A short image keeps the copy brief.
    logic clock = 1'b0, rst_n = 1'b0, master_reset_n = 1'b0;
    logic enumeration_done = 1'b0, usb_download_done = 1'b0, vbus_present = 1'b1, self_powered = 1'b0;
    logic fw_connect = 1'b0, fw_high_power = 1'b0, fw_low_power = 1'b0, fw_pull_up = 1'b0, fw_pull_down = 1'b0;
    // Wake pins idle high, as their pullups hold them.
    logic wake_enable = 1'b0, wake_input_a = 1'b1, wake_input_b = 1'b1, card_detect_a = 1'b1, card_detect_b = 1'b1;
    logic good_sig = 1'b1, enum_first = 1'b0, slow = 1'b0; // EEPROM model settings.
    logic [15:0] err_at = 16'hFFFF; // No failing address at first.
    logic ee_read_req, ee_read_done, ee_read_error, ram_write, usb_connect, usb_download_mode, cpu_run;
    logic boot_done, remote_wake, low_power_grant_o, low_power_grant_oe, high_power_grant_o, high_power_grant_oe;
    logic port_pin_pulldown_default_pu, port_pin_pulldown_default_pd;
    logic [15:0] ee_read_addr, vendor_id, product_id, cpu_fetch_addr;
    logic [7:0] ee_read_data, ram_data;
    logic [6:0] usb_address;
    logic [boot_seq_pkg::CODE_ADDR_W-1:0] ram_addr;
    int n_errors = 0, cmp_count = 0, n_writes = 0;
    reset_boot_sequencer #(.BOOT_SIGNATURE(16'hA55A), .IMAGE_BYTES(IMG), .DEBOUNCE(16)) i_dut (.*);
    ee_model i_ee (.*);
    always #25 clock = ~clock;
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Inputs always change 5 ns after the rising edge.
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask
    // Selectors of the flags that a bounded wait can watch.
    localparam int W_DONE = 0;
    localparam int W_CONN = 1;
    localparam int W_LOAD = 2;
    // Returns the flag picked by a selector.
    function automatic logic flag(input int sel);
        case (sel)
            W_DONE: return boot_done;
            W_CONN: return usb_connect;
            default: return usb_download_mode;
        endcase
    endfunction
    // Waits a bounded time for a flag; running out counts as a mismatch.
    task automatic wait_hi(input int sel, input int lim);
        for (int i = 0; i < lim && flag(sel) !== 1'b1; i++) step(1);
        chk(flag(sel), 1'b1);
    endtask
    // Restarts the boot through the master reset with new EEPROM contents.
    task automatic restart(input logic g, input logic e, input logic [15:0] er);
        master_reset_n = 1'b0;
        {good_sig, enum_first, err_at, n_writes} = {g, e, er, 32'h0};
        step(3);
        master_reset_n = 1'b1;
    endtask
    // Ends the download from the host side and waits for hand-off.
    task automatic usb_load;
        usb_download_done = 1'b1;
        step(1);
        usb_download_done = 1'b0;
        wait_hi(W_DONE, 50);
    endtask
    // Each code write must carry the next image byte at the next address.
    always @(negedge clock) begin
        if (ram_write === 1'b1) begin
            chk(ram_addr, 16'(n_writes));
            chk(ram_data, 8'(boot_seq_pkg::HDR_IMAGE_ADDR + n_writes) ^ 8'h3C);
            n_writes++;
        end
    end
    task automatic t_reset;
        chk(usb_address, 7'h00);
        chk(usb_connect, 1'b0);
        chk(boot_done, 1'b0);
        chk(low_power_grant_oe, 1'b0);
        chk(cpu_fetch_addr, 16'h0000);
        chk({low_power_grant_o, high_power_grant_o, high_power_grant_oe}, 3'h0);
        chk(port_pin_pulldown_default_pd, 1'b1);
        chk(port_pin_pulldown_default_pu, 1'b0);
    endtask
    // EEPROM boot, then firmware takes over the pins that it owns.
    task automatic t_ee_boot;
        wait_hi(W_DONE, 400);
        chk(16'(n_writes), 16'(IMG));
        chk(vendor_id, 16'h1234);
        chk(product_id, 16'h5678);
        chk(usb_connect, 1'b0);
        chk(usb_download_mode, 1'b0);
        chk(cpu_run, 1'b1);
        chk(cpu_fetch_addr, 16'h0000);
        chk(high_power_grant_oe, 1'b0);
        {fw_high_power, fw_connect, fw_pull_up, fw_low_power} = 4'hF;
        step(3);
        chk(high_power_grant_oe, 1'b1);
        chk({low_power_grant_o, high_power_grant_o}, 2'h0);
        chk(usb_connect, 1'b1);
        chk(low_power_grant_oe, 1'b1);
        chk(port_pin_pulldown_default_pu, 1'b1);
        chk(port_pin_pulldown_default_pd, 1'b0);
        {fw_high_power, fw_connect, fw_pull_up, fw_low_power} = 4'h0;
    endtask
    // Every wake source raises a wake only while wake-up is enabled.
    // Each source is pulled low for a while and then let back to its idle high.
    task automatic t_wake;
        int hits;
        for (int en = 1; en >= 0; en--) begin
            wake_enable = en[0];
            hits = 0;
            for (int k = 0; k < 4; k++) begin
                {wake_input_a, wake_input_b, card_detect_a, card_detect_b} = ~(4'h8 >> k);
                repeat (6) begin
                    step(1);
                    if (remote_wake === 1'b1) hits++;
                end
                {wake_input_a, wake_input_b, card_detect_a, card_detect_b} = 4'hF;
                step(6);
            end
            chk(16'(hits), en[0] ? 16'h0004 : 16'h0000);
        end
    endtask
    task automatic t_usb_enum;
        restart(1'b0, 1'b1, 16'hFFFF);
        chk(port_pin_pulldown_default_pd, 1'b1);
        chk(usb_connect, 1'b0);
        wait_hi(W_CONN, 400);
        chk(low_power_grant_oe, 1'b1);
        chk(vendor_id, 16'h1234);
        enumeration_done = 1'b1;
        step(1);
        enumeration_done = 1'b0;
        wait_hi(W_LOAD, 50);
        usb_load();
        chk(16'(n_writes), 16'h0000);
    endtask
    // A self-powered product without bus power leaves the low grant off.
    task automatic t_self_powered;
        {self_powered, vbus_present} = 2'b10;
        restart(1'b0, 1'b0, 16'hFFFF);
        wait_hi(W_LOAD, 400);
        chk(usb_connect, 1'b0);
        step(2);
        chk(low_power_grant_oe, 1'b0);
        usb_load();
        {self_powered, vbus_present} = 2'b01;
    endtask
    // A failed signature read with slow answers falls back to the host; then an
    // enumerate-first image whose third byte fails is cut short after two writes.
    task automatic t_ee_error;
        slow = 1'b1;
        restart(1'b1, 1'b0, 16'h0000);
        wait_hi(W_LOAD, 400);
        usb_load();
        chk(16'(n_writes), 16'h0000);
        restart(1'b1, 1'b1, 16'h0012);
        wait_hi(W_CONN, 400);
        enumeration_done = 1'b1;
        step(1);
        enumeration_done = 1'b0;
        wait_hi(W_LOAD, 100);
        chk(16'(n_writes), 16'h0002);
        usb_load();
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Reset is held for 20 cycles, then the scenarios run in turn.
    initial begin
        step(19);
        t_reset();
        step(1);
        {rst_n, master_reset_n} = 2'b11;
        t_ee_boot();
        t_wake();
        t_usb_enum();
        t_self_powered();
        t_ee_error();
        close_out();
    end
    // The scenarios need a few hundred cycles; this cuts a hang short.
    initial begin
        #1000000;
        n_errors++;
        close_out();
    end
endmodule // reset_boot_sequencer_tb_top
`default_nettype wire
